// File: rtl/prsd_defs.svh
// Function
// - Bus clock is reference times strap-selected ratio, e.g. 01001 gives 2.
// - Processor clock is bus clock times strap-selected ratio, e.g. 01110 gives 3.
// - Strap all ones selects clock-off: both multipliers off, no internal clocking.
// - Sampled strap value reads back in bits 8 to 4 of register 0xe2.
// - Single bypass: reference clocks processor, peripheral PLL off, bus ratio 1:1.
// - Dual bypass: reference clocks peripheral 1:1, bypass input clocks processor, PLLs off.
`ifndef PRSD_DEFS_SVH
`define PRSD_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PRSD_STRAP_IDX      8'he2
`define PRSD_STRAP_ADDR     12'h388
`define PRSD_MODE_ADDR      12'h38c
`define PRSD_STRAP_LSB      4
`define PRSD_MODE_LSB       0
`define PRSD_MEMVCO_LSB     8
`define PRSD_CPUVCO_LSB     12
`define PRSD_MEMR_LSB       16
`define PRSD_CPUR_LSB       24

// ----------------------------------------
// Ratios in half units, 2 means 1.0
// ----------------------------------------
`define PRSD_CODE_OFF       5'h1f
`define PRSD_CODE_BYP1      5'h03
`define PRSD_CODE_BYP1B     5'h07
`define PRSD_CODE_BYP2      5'h06
`define PRSD_RATIO_ONE      8'h02

`endif

// File: rtl/prsd_pkg.sv
package prsd_pkg;
   typedef enum logic [2:0] {
      PRSD_MODE_PLL      = 3'h0,
      PRSD_MODE_BYPASS1  = 3'h1,
      PRSD_MODE_BYPASS2  = 3'h2,
      PRSD_MODE_OFF      = 3'h3,
      PRSD_MODE_RESERVED = 3'h4
   } prsd_mode_e;

   typedef struct packed {
      prsd_mode_e mode;
      logic [7:0] mem_ratio_x2;
      logic [7:0] cpu_ratio_x2;
      logic [3:0] mem_vco_mul;
      logic [3:0] cpu_vco_mul;
      logic       mem_pll_en;
      logic       cpu_pll_en;
      logic       cpu_from_ref;
      logic       cpu_from_byp;
      logic       clocks_on;
   } prsd_cfg_s;
endpackage

// File: rtl/prsd_decode.sv
`timescale 1ns/1ps
`include "prsd_defs.svh"
module prsd_decode (
   input  wire logic [4:0]         strap,
   output prsd_pkg::prsd_cfg_s     cfg
);
   // ----------------------------------------
   // Ratio table, memory and cpu in half units
   // ----------------------------------------
   function automatic logic [23:0] ratio_row(input logic [4:0] c);
      // {mem_x2, cpu_x2, mem_vco, cpu_vco}
      unique case (c)
         5'h00: ratio_row = {8'h06, 8'h05, 4'h2, 4'h2};
         5'h01: ratio_row = {8'h06, 8'h06, 4'h2, 4'h2};
         5'h02: ratio_row = {8'h02, 8'h09, 4'h4, 4'h2};
         5'h03: ratio_row = {8'h02, 8'h04, 4'h0, 4'h4};
         5'h04: ratio_row = {8'h04, 8'h04, 4'h4, 4'h4};
         5'h07: ratio_row = {8'h02, 8'h06, 4'h0, 4'h2};
         5'h08: ratio_row = {8'h02, 8'h06, 4'h4, 4'h2};
         5'h09: ratio_row = {8'h04, 8'h04, 4'h2, 4'h2};
         5'h0a: ratio_row = {8'h04, 8'h09, 4'h4, 4'h2};
         5'h0b: ratio_row = {8'h03, 8'h06, 4'h2, 4'h2};
         5'h0c: ratio_row = {8'h04, 8'h05, 4'h4, 4'h2};
         5'h0d: ratio_row = {8'h03, 8'h07, 4'h2, 4'h2};
         5'h0e: ratio_row = {8'h04, 8'h06, 4'h4, 4'h2};
         5'h0f: ratio_row = {8'h06, 8'h07, 4'h2, 4'h2};
         5'h10: ratio_row = {8'h06, 8'h04, 4'h2, 4'h2};
         5'h11: ratio_row = {8'h08, 8'h05, 4'h2, 4'h2};
         5'h12: ratio_row = {8'h03, 8'h04, 4'h2, 4'h2};
         default: ratio_row = 24'h000000;
      endcase
   endfunction

   logic [23:0] row;

   always_comb begin
      row = ratio_row(strap);
      cfg = '0;
      cfg.mem_ratio_x2 = row[23:16];
      cfg.cpu_ratio_x2 = row[15:8];
      cfg.mem_vco_mul  = row[7:4];
      cfg.cpu_vco_mul  = row[3:0];
      if (strap == `PRSD_CODE_OFF) begin
         cfg.mode = prsd_pkg::PRSD_MODE_OFF;
      end else if (strap == `PRSD_CODE_BYP2) begin
         cfg.mode         = prsd_pkg::PRSD_MODE_BYPASS2;
         cfg.mem_ratio_x2 = `PRSD_RATIO_ONE;
         cfg.cpu_ratio_x2 = `PRSD_RATIO_ONE;
         cfg.cpu_from_byp = 1'b1;
         cfg.clocks_on    = 1'b1;
      end else if (strap == `PRSD_CODE_BYP1 || strap == `PRSD_CODE_BYP1B) begin
         cfg.mode         = prsd_pkg::PRSD_MODE_BYPASS1;
         cfg.mem_ratio_x2 = `PRSD_RATIO_ONE;
         cfg.cpu_pll_en   = 1'b1;
         cfg.cpu_from_ref = 1'b1;
         cfg.clocks_on    = 1'b1;
      end else if (row != 24'h000000) begin
         cfg.mode       = prsd_pkg::PRSD_MODE_PLL;
         cfg.mem_pll_en = 1'b1;
         cfg.cpu_pll_en = 1'b1;
         cfg.clocks_on  = 1'b1;
      end else begin
         // Reserved codes park everything off rather than guess a ratio
         cfg.mode = prsd_pkg::PRSD_MODE_RESERVED;
      end
   end
endmodule

// File: rtl/prsd_top.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "prsd_defs.svh"
module prsd_top (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               hard_reset_b,
   input  wire logic [4:0]         pll_strap,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   output prsd_pkg::prsd_cfg_s     clk_cfg
);
   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   logic [4:0]          strap_q;
   prsd_pkg::prsd_cfg_s dec;

   // Samples the strap while hard reset is low, then holds it once released
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_q <= 5'h1f;
      end else if (!hard_reset_b) begin
         strap_q <= pll_strap;
      end
   end

   prsd_decode u_dec (
      .strap (strap_q),
      .cfg   (dec)
   );

   // Output held while hard reset runs so clocks stay off until released
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_cfg <= '0;
      end else if (!hard_reset_b) begin
         clk_cfg <= '0;
      end else begin
         clk_cfg <= dec;
      end
   end

   // ----------------------------------------
   // APB slave, one wait-free access phase
   // ----------------------------------------
   logic        acc;
   logic [31:0] rd_d;
   assign acc = psel && !penable;

   always_comb begin
      rd_d = 32'h00000000;
      unique case (paddr)
         `PRSD_STRAP_ADDR: rd_d[`PRSD_STRAP_LSB +: 5] = strap_q;
         `PRSD_MODE_ADDR: begin
            rd_d[`PRSD_MODE_LSB +: 3]   = clk_cfg.mode;
            rd_d[`PRSD_MEMVCO_LSB +: 4] = clk_cfg.mem_vco_mul;
            rd_d[`PRSD_CPUVCO_LSB +: 4] = clk_cfg.cpu_vco_mul;
            rd_d[`PRSD_MEMR_LSB +: 8]   = clk_cfg.mem_ratio_x2;
            rd_d[`PRSD_CPUR_LSB +: 8]   = clk_cfg.cpu_ratio_x2;
         end
         default: rd_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc;
         pslverr <= acc && (pwrite || (paddr != `PRSD_STRAP_ADDR && paddr != `PRSD_MODE_ADDR));
         if (acc && !pwrite) begin
            prdata <= rd_d;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_off_no_clock: assert property (@(posedge clk) disable iff (!rst_b)
      (hard_reset_b && $past(hard_reset_b) && strap_q == 5'h1f) |=> !clk_cfg.clocks_on
         && !clk_cfg.mem_pll_en && !clk_cfg.cpu_pll_en)
      else $error("clock-off strap left clocks running");
   chk_bypass_one: assert property (@(posedge clk) disable iff (!rst_b)
      (hard_reset_b && strap_q == 5'h03) |=> (clk_cfg.mode == prsd_pkg::PRSD_MODE_BYPASS1
         && !clk_cfg.mem_pll_en && clk_cfg.mem_ratio_x2 == 8'h02 && clk_cfg.cpu_from_ref))
      else $error("single bypass decode wrong");
   chk_bypass_two: assert property (@(posedge clk) disable iff (!rst_b)
      (hard_reset_b && strap_q == 5'h06) |=> (clk_cfg.cpu_from_byp && !clk_cfg.cpu_pll_en
         && !clk_cfg.mem_pll_en && clk_cfg.cpu_ratio_x2 == 8'h02))
      else $error("dual bypass decode wrong");
   chk_mem_ratio: assert property (@(posedge clk) disable iff (!rst_b)
      (hard_reset_b && strap_q == 5'h0b) |=> clk_cfg.mem_ratio_x2 == 8'h03)
      else $error("bus ratio for 01011 not 1.5");
   chk_cpu_ratio: assert property (@(posedge clk) disable iff (!rst_b)
      (hard_reset_b && strap_q == 5'h11) |=> clk_cfg.cpu_ratio_x2 == 8'h05)
      else $error("cpu ratio for 10001 not 2.5");
   chk_strap_held: assert property (@(posedge clk) disable iff (!rst_b)
      hard_reset_b |=> $stable(strap_q))
      else $error("strap changed outside hard reset");
   chk_strap_read: assert property (@(posedge clk) disable iff (!rst_b)
      (acc && !pwrite && paddr == 12'h388) |=> pready && prdata[8:4] == $past(strap_q)
         && prdata[31:9] == 23'h0)
      else $error("strap readback wrong");
   chk_apb_ready: assert property (@(posedge clk) disable iff (!rst_b)
      (psel && penable) |-> pready)
      else $error("access phase without ready");
endmodule

// File: tb/prsd_board.sv
`timescale 1ns/1ps
// ----
// Strap board: holds hard reset for four cycles, then the pins are reused
// ----
module prsd_board (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [4:0] code,
   output logic            hard_reset_b,
   output logic [4:0]      pll_strap
);
   logic [2:0] cnt_q = 3'h0;
   // Reference and bypass inputs come from one source, so they stay in step
   localparam int REF_MHZ = 33;

   always_ff @(posedge clk) begin
      if (go) begin
         cnt_q <= 3'h4;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end

   assign hard_reset_b = (cnt_q == 3'h0);
   // Only listed codes are handed in; pins toggle once reset is gone
   assign pll_strap = hard_reset_b ? ~code : code;
endmodule

// File: tb/prsd_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_fail++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module prsd_top_tb;
   logic clk = 1'b0, rst_b = 1'b0, go = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rd;
   logic [4:0]  code = 5'h09, pll_strap;
   logic        hard_reset_b, pready, pslverr, err;
   logic [31:0] prdata;
   prsd_pkg::prsd_cfg_s clk_cfg;
   int n_fail = 0, check_count = 0;
   // {code, mem ratio x2, cpu ratio x2}; listed codes only, rates in range
   localparam logic [23:0] TBL [19] = '{24'h000605, 24'h010606, 24'h020209,
      24'h030204, 24'h040404, 24'h060202, 24'h070206, 24'h080206, 24'h090404,
      24'h0a0409, 24'h0b0306, 24'h0c0405, 24'h0d0307, 24'h0e0406, 24'h0f0607,
      24'h100604, 24'h110805, 24'h120304, 24'h1f0000};

   prsd_board board (.clk(clk), .go(go), .code(code), .hard_reset_b(hard_reset_b),
      .pll_strap(pll_strap));
   prsd_top uut (.clk(clk), .rst_b(rst_b), .hard_reset_b(hard_reset_b),
      .pll_strap(pll_strap), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .clk_cfg(clk_cfg));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Straps one code through a hard reset and checks decode and readback
   task automatic run(input logic [23:0] t);
      logic [2:0] m;
      int n;
      n = 0;
      m = (t[20:16] == 5'h1f) ? 3'h3 : (t[20:16] == 5'h06) ? 3'h2 :
          (t[20:16] == 5'h03 || t[20:16] == 5'h07) ? 3'h1 : 3'h0;
      @(posedge clk);
      code <= t[20:16];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do begin @(posedge clk); n++; end while (hard_reset_b !== 1'b1 && n < 20);
      repeat (3) @(posedge clk);
      #1;
      `CHK("mode", m, clk_cfg.mode)
      if (m == 3'h0) begin
         `CHK("mem_ratio", t[15:8], clk_cfg.mem_ratio_x2)
         `CHK("cpu_ratio", t[7:0], clk_cfg.cpu_ratio_x2)
         `CHK("pll_on", 3'h7, {clk_cfg.mem_pll_en, clk_cfg.cpu_pll_en, clk_cfg.clocks_on})
      end else if (m == 3'h1) begin
         `CHK("byp1", 10'h102, {clk_cfg.mem_pll_en, clk_cfg.cpu_from_ref, clk_cfg.mem_ratio_x2})
      end else if (m == 3'h2) begin
         `CHK("byp2", 19'h00202, {clk_cfg.mem_pll_en, clk_cfg.cpu_pll_en, ~clk_cfg.cpu_from_byp,
            clk_cfg.mem_ratio_x2, clk_cfg.cpu_ratio_x2})
      end else begin
         `CHK("off", 3'h0, {clk_cfg.mem_pll_en, clk_cfg.cpu_pll_en, clk_cfg.clocks_on})
      end
      apb(1'b0, 12'h388, 32'h0);
      `CHK("strap", {1'b0, t[20:16]}, {err, rd[8:4]})
      apb(1'b0, 12'h38c, 32'h0);
      `CHK("mode_reg", m, rd[2:0])
      `CHK("ratio_reg", {t[7:0], t[15:8]}, rd[31:16])
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      test_done();
   end

   initial begin
      void'($urandom(35));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      foreach (TBL[i]) run(TBL[i]);
      repeat (10) begin
         run(TBL[$urandom % 19]);
         apb(1'b1, 12'h388, $urandom);
         `CHK("wr_err", 1'b1, err)
         apb(1'b0, 12'h388, 32'h0);
         `CHK("strap_held", code, rd[8:4])
      end
      apb(1'b0, 12'h100, 32'h0);
      `CHK("unmapped", 33'h100000000, {err, rd})
      test_done();
   end
endmodule
